// [common/dsras_pkg.sv]
`default_nettype none
package dsras_pkg;

    // ------------------------------------------------------------------
    // register map and field positions
    // ------------------------------------------------------------------
    localparam int unsigned NREG = 64;
    localparam logic [6:0] SLAVE_ADDR = 7'h1d;
    localparam logic [5:0] REG_DEV_ADDR = 6'h0d;
    localparam logic [5:0] REG_MODE_CTL = 6'h16;
    localparam int unsigned TWD_POS = 7;
    localparam int unsigned THREE_WIRE_POS = 5;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------------
    // serial framing counts
    // ------------------------------------------------------------------
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] IDX_LAST_BIT = 3'h6;
    localparam logic [2:0] FIRST_BIT = 3'h0;

    typedef logic [NREG-1:0][7:0] dsras_regs_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INDEX, ST_INDEX_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_MACK
    } dsras_i2c_st_t;

    // write request carried from the link clock into the system clock
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] data;
    } dsras_wreq_t;

    // system clock state: synchronisers, two-wire engine, register file
    typedef struct packed {
        logic cs_m, cs_s;
        logic scl_m, scl_s, scl_p;
        logic sda_m, sda_s, sda_p;
        logic a0_m, a0_s;
        logic wt_m, wt_s, wt_p;
        logic rt_m, rt_s, rt_p;
        logic irq1, irq2;
        dsras_i2c_st_t st;
        logic [2:0] cnt;
        logic [7:0] shift;
        logic rw, mack, sda_oe;
        logic [5:0] idx;
        logic [7:0] rd_hold;
        dsras_regs_t regs;
    } dsras_sys_t;

    // link clock state, rising edge, cleared while chip select is high
    typedef struct packed {
        logic first, rw, rd_ph;
        logic [2:0] cnt;
        logic [5:0] idx;
        logic [6:0] shift;
    } dsras_lrx_t;

    // link clock state, falling edge, cleared while chip select is high
    typedef struct packed {
        logic drive;
        logic [7:0] out;
    } dsras_ltx_t;

    // link clock state that must survive the end of a frame
    typedef struct packed {
        logic wtog, rtog, tw_m, tw_s;
        logic [5:0] ridx;
        dsras_wreq_t wreq;
    } dsras_lxf_t;

    // bus line copies start at the idle high level, so no false edge
    localparam dsras_sys_t SYS_RST = '{st: ST_IDLE, scl_m: 1'b1,
        scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
        default: '0};
    localparam dsras_lrx_t LRX_RST = '{first: 1'b1, default: '0};
    localparam dsras_ltx_t LTX_RST = '0;
    localparam dsras_lxf_t LXF_RST = '0;

endpackage
`default_nettype wire

// [hdl/dsras_spi_link.sv]
`timescale 1ns/1ns
`default_nettype none
module dsras_spi_link (
    input wire logic serial_port_clock,
    input wire logic cs_n,
    input wire logic resetn,
    input wire logic sdi,
    input wire logic three_wire_select,
    input wire logic [7:0] rd_hold,
    output logic rd_tog,
    output logic [5:0] rd_idx,
    output logic wr_tog,
    output dsras_pkg::dsras_wreq_t wr_req,
    output logic spi_do,
    output logic sdo_oe,
    output logic sdio_spi_oe
);
    import dsras_pkg::*;

    dsras_lrx_t rx_q, rx_d;
    dsras_ltx_t tx_q, tx_d;
    dsras_lxf_t xf_q, xf_d;
    logic rd_cmd, rd_next, wr_done;

    // ------------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------------
    // command byte: direction, six index bits, one ignored bit
    assign rd_cmd = rx_q.first && rx_q.cnt == IDX_LAST_BIT && !rx_q.shift[5];
    assign rd_next = rx_q.rd_ph && rx_q.cnt == FIRST_BIT;
    assign wr_done = !rx_q.first && rx_q.rw && rx_q.cnt == LAST_BIT;

    // sample on the rising edge, one bit per clock in groups of eight
    always_comb
    begin
        rx_d = rx_q;
        rx_d.shift = {rx_q.shift[5:0], sdi}; // R12
        rx_d.cnt = rx_q.cnt + 3'h1; // R13
        if (rx_q.first && rx_q.cnt == IDX_LAST_BIT)
        begin
            rx_d.rw = rx_q.shift[5]; // R14 R15
            rx_d.idx = {rx_q.shift[4:0], sdi};
        end
        if (rx_q.first && rx_q.cnt == LAST_BIT)
        begin
            rx_d.first = 1'b0;
            rx_d.rd_ph = !rx_q.rw; // R14
        end
        if (wr_done || rd_next)
        begin
            rx_d.idx = rx_q.idx + 6'h01; // R13
        end
    end

    // the frame ends with chip select, so no edge is needed to clear it
    always_ff @(posedge serial_port_clock or posedge cs_n) // R11
    begin
        if (cs_n)
            rx_q <= LRX_RST;
        else
            rx_q <= rx_d;
    end

    // ------------------------------------------------------------------
    // read data out, changed on the falling edge
    // ------------------------------------------------------------------
    // rd_hold settles many system clocks before this edge reads it
    always_comb
    begin
        tx_d = tx_q;
        tx_d.drive = rx_q.rd_ph;
        if (rx_q.rd_ph && rx_q.cnt == FIRST_BIT)
            tx_d.out = rd_hold; // R14
        else
            tx_d.out = {tx_q.out[6:0], 1'b0}; // R12
    end

    always_ff @(negedge serial_port_clock or posedge cs_n)
    begin
        if (cs_n)
            tx_q <= LTX_RST;
        else
            tx_q <= tx_d;
    end

    // ------------------------------------------------------------------
    // requests to the system clock, kept across frames
    // ------------------------------------------------------------------
    // a toggle per event; index and data stay put until the next one
    always_comb
    begin
        xf_d = xf_q;
        xf_d.tw_m = three_wire_select;
        xf_d.tw_s = xf_q.tw_m;
        if (rd_cmd)
        begin
            xf_d.rtog = !xf_q.rtog;
            xf_d.ridx = {rx_q.shift[4:0], sdi};
        end
        else if (rd_next)
        begin
            xf_d.rtog = !xf_q.rtog;
            xf_d.ridx = rx_q.idx + 6'h01;
        end
        if (wr_done)
        begin
            xf_d.wtog = !xf_q.wtog; // R15
            xf_d.wreq = '{idx: rx_q.idx, data: {rx_q.shift, sdi}};
        end
    end

    always_ff @(posedge serial_port_clock or negedge resetn)
    begin
        if (!resetn)
            xf_q <= LXF_RST;
        else
            xf_q <= xf_d;
    end

    assign rd_tog = xf_q.rtog;
    assign rd_idx = xf_q.ridx;
    assign wr_tog = xf_q.wtog;
    assign wr_req = xf_q.wreq;
    assign spi_do = tx_q.out[7]; // R7
    // dedicated output in four-wire mode, shared pin in three-wire mode
    assign sdo_oe = tx_q.drive && !xf_q.tw_s; // R16
    assign sdio_spi_oe = tx_q.drive && xf_q.tw_s; // R16

endmodule
`default_nettype wire

// [hdl/dsras_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// (R1) chip select low selects the peripheral link; high selects two-wire bus
// (R2) host should set the two-wire disable bit over the peripheral link
// (R3) two-wire side is slave only, answering address 1d hex
// (R4) no high-speed, ten-bit, general call or start byte answer
// (R5) read: address write, index, repeated start, address read, data back
// (R6) host ends a read with not-acknowledge and then stop
// (R7) read data leaves most significant bit first
// (R8) two-wire read index advances per byte sent, until not-acknowledge
// (R9) write: address, index, data byte, each acknowledged, data stored
// (R10) two-wire write index advances after each acknowledged data byte
// (R11) host drives link clock and chip select, low for a frame
// (R12) outputs change on falling link clock, inputs sampled on rising
// (R13) sixteen clocks per single access, eight more per extra byte
// (R14) read command: direction 0, six index bits, one ignored bit
// (R15) write command: direction 1, six index bits, ignored bit, data
// (R16) four-wire read on dedicated pin, three-wire on shared data pin
// (R17) first interrupt pin doubles as data ready; second pin separate
// (R18) address bit 0 may come from a strap pin
// (R19) two-wire disable bit writable; slave address bits read only
// (R20) mode control bit picks three-wire, four-wire after reset
module dsras_top (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic serial_port_clock,
    input wire logic cs_n,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe,
    output logic sdo_o,
    output logic sdo_oe,
    input wire logic slave_addr_bit0_pin,
    input wire logic core_data_ready,
    input wire logic core_irq1,
    input wire logic core_irq2,
    output logic first_irq_or_data_ready_pin,
    output logic second_irq_pin
);
    import dsras_pkg::*;

    dsras_sys_t q, d;
    logic rd_tog, wr_tog, spi_do, sdio_spi_oe;
    logic [5:0] rd_idx;
    dsras_wreq_t wr_req;
    logic rise, fall, start, stop, en, match, wr_evt, rd_evt;
    logic [6:0] own_addr;

    // ------------------------------------------------------------------
    // register access helpers
    // ------------------------------------------------------------------
    // address register shows the live slave address in its low bits
    function automatic logic [7:0] rd_reg(
        input dsras_regs_t r,
        input logic [5:0] i,
        input logic [6:0] a
    );
        if (i == REG_DEV_ADDR)
            return {r[i][TWD_POS], a}; // R19
        return r[i];
    endfunction

    // only the disable bit of the address register takes a write
    function automatic logic [7:0] wr_val(
        input logic [5:0] i,
        input logic [7:0] v
    );
        if (i == REG_DEV_ADDR)
            return {v[TWD_POS], REG_RESET[6:0]}; // R19
        return v;
    endfunction

    // ------------------------------------------------------------------
    // peripheral link end, on the link clock
    // ------------------------------------------------------------------
    dsras_spi_link u_link (
        .serial_port_clock(serial_port_clock),
        .cs_n(cs_n),
        .resetn(resetn),
        .sdi(sdio_i),
        .three_wire_select(q.regs[REG_MODE_CTL][THREE_WIRE_POS]), // R20
        .rd_hold(q.rd_hold),
        .rd_tog(rd_tog),
        .rd_idx(rd_idx),
        .wr_tog(wr_tog),
        .wr_req(wr_req),
        .spi_do(spi_do),
        .sdo_oe(sdo_oe),
        .sdio_spi_oe(sdio_spi_oe)
    );

    // ------------------------------------------------------------------
    // bus conditions seen on the system clock
    // ------------------------------------------------------------------
    assign rise = q.scl_s && !q.scl_p;
    assign fall = !q.scl_s && q.scl_p;
    assign start = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
    assign stop = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
    assign en = q.cs_s && !q.regs[REG_DEV_ADDR][TWD_POS]; // R1 R2
    assign own_addr = {SLAVE_ADDR[6:1], q.a0_s}; // R18
    // exact match also rejects general call, start byte and ten-bit heads
    assign match = q.shift[7:1] == own_addr; // R3 R4
    assign wr_evt = q.wt_s ^ q.wt_p;
    assign rd_evt = q.rt_s ^ q.rt_p;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        d = q;
        // pins and link toggles each pass two flops first
        d.cs_m = cs_n;
        d.cs_s = q.cs_m;
        d.scl_m = serial_port_clock;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = sdio_i;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.a0_m = slave_addr_bit0_pin;
        d.a0_s = q.a0_m;
        d.wt_m = wr_tog;
        d.wt_s = q.wt_m;
        d.wt_p = q.wt_s;
        d.rt_m = rd_tog;
        d.rt_s = q.rt_m;
        d.rt_p = q.rt_s;
        d.irq1 = core_data_ready || core_irq1; // R17
        d.irq2 = core_irq2; // R17
        // link requests; only one side is selected at a time
        if (wr_evt)
            d.regs[wr_req.idx] = wr_val(wr_req.idx, wr_req.data); // R15
        if (rd_evt)
            d.rd_hold = rd_reg(q.regs, rd_idx, own_addr); // R14
        // two-wire engine
        if (!en || stop)
        begin
            d.st = ST_IDLE; // R1
            d.sda_oe = 1'b0;
        end
        else if (start)
        begin
            d.st = ST_ADDR; // R5
            d.cnt = FIRST_BIT;
            d.sda_oe = 1'b0;
        end
        else
        begin
            case (q.st)
                ST_IDLE:
                    d.st = ST_IDLE;
                ST_ADDR, ST_INDEX, ST_WDATA:
                    if (rise)
                    begin
                        d.shift = {q.shift[6:0], q.sda_s};
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == LAST_BIT)
                        begin
                            if (q.st == ST_ADDR)
                                d.st = ST_ADDR_ACK;
                            else if (q.st == ST_INDEX)
                                d.st = ST_INDEX_ACK;
                            else
                                d.st = ST_WDATA_ACK;
                        end
                    end
                ST_ADDR_ACK:
                    if (fall && !q.sda_oe)
                    begin
                        d.sda_oe = match; // R3
                        d.rw = q.shift[0];
                        if (!match)
                            d.st = ST_IDLE; // R4
                    end
                    else if (fall && q.rw)
                    begin
                        d.shift = rd_reg(q.regs, q.idx, own_addr); // R5
                        d.sda_oe = !d.shift[7]; // R7
                        d.cnt = FIRST_BIT;
                        d.st = ST_RDATA;
                    end
                    else if (fall)
                    begin
                        d.sda_oe = 1'b0;
                        d.cnt = FIRST_BIT;
                        d.st = ST_INDEX;
                    end
                ST_INDEX_ACK:
                    if (fall && !q.sda_oe)
                        d.sda_oe = 1'b1; // R5
                    else if (fall)
                    begin
                        d.sda_oe = 1'b0;
                        d.idx = q.shift[5:0];
                        d.cnt = FIRST_BIT;
                        d.st = ST_WDATA;
                    end
                ST_WDATA_ACK:
                    if (fall && !q.sda_oe)
                    begin
                        d.sda_oe = 1'b1;
                        d.regs[q.idx] = wr_val(q.idx, q.shift); // R9
                        d.idx = q.idx + 6'h01; // R10
                    end
                    else if (fall)
                    begin
                        d.sda_oe = 1'b0;
                        d.cnt = FIRST_BIT;
                        d.st = ST_WDATA;
                    end
                ST_RDATA:
                    if (rise)
                    begin
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == LAST_BIT)
                        begin
                            d.idx = q.idx + 6'h01; // R8
                            d.mack = 1'b0;
                            d.st = ST_MACK;
                        end
                    end
                    else if (fall)
                    begin
                        d.shift = {q.shift[6:0], 1'b0}; // R7
                        d.sda_oe = !q.shift[6];
                    end
                ST_MACK:
                    // host answer: low asks for more, high ends the read
                    if (rise && q.sda_s)
                        d.st = ST_IDLE; // R6 R8
                    else if (rise)
                        d.mack = 1'b1;
                    else if (fall && q.mack)
                    begin
                        d.shift = rd_reg(q.regs, q.idx, own_addr); // R8
                        d.sda_oe = !d.shift[7];
                        d.cnt = FIRST_BIT;
                        d.st = ST_RDATA;
                    end
                    else if (fall)
                        d.sda_oe = 1'b0;
                default:
                    d.st = ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            q <= SYS_RST;
        else
            q <= d;
    end

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    // shared pin: the two-wire side is open drain and only ever pulls low; the link drives both levels
    assign sdio_o = cs_n ? 1'b0 : spi_do; // R16
    assign sdio_oe = cs_n ? q.sda_oe : sdio_spi_oe; // R1 R16
    assign sdo_o = spi_do;
    assign first_irq_or_data_ready_pin = q.irq1;
    assign second_irq_pin = q.irq2;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    cs_select_a: assert property ( // R1
        !q.cs_s |=> q.st == ST_IDLE && !q.sda_oe)
        else $error("two-wire engine active while link selected");
    twd_off_a: assert property ( // R2
        en == 1'b0 && q.cs_s |=> q.st == ST_IDLE)
        else $error("two-wire engine active while disabled");
    addr_nack_a: assert property ( // R3 R4
        q.st == ST_ADDR_ACK && fall && !q.sda_oe && !match && !stop
        && !start && en |=> !q.sda_oe && q.st == ST_IDLE)
        else $error("foreign address acknowledged");
    addr_ack_a: assert property ( // R5
        q.st == ST_ADDR_ACK && fall && !q.sda_oe && match && !stop
        && !start && en |=> q.sda_oe)
        else $error("own address not acknowledged");
    rd_msb_a: assert property ( // R7
        q.st != ST_RDATA ##1 q.st == ST_RDATA |-> q.sda_oe == !q.shift[7])
        else $error("read byte not started with its top bit");
    rd_inc_a: assert property ( // R8
        q.st == ST_RDATA && rise && q.cnt == LAST_BIT && en && !stop
        && !start |=> q.st == ST_MACK && q.idx == $past(q.idx) + 6'h01)
        else $error("read index did not advance");
    nack_end_a: assert property ( // R6
        q.st == ST_MACK && rise && q.sda_s && en |=> q.st == ST_IDLE)
        else $error("read went on after not-acknowledge");
    wr_store_a: assert property ( // R9 R10
        q.st == ST_WDATA_ACK && fall && !q.sda_oe && en && !stop && !start
        && !wr_evt && q.idx != REG_DEV_ADDR
        |=> q.regs[$past(q.idx)] == $past(q.shift)
        && q.idx == $past(q.idx) + 6'h01)
        else $error("two-wire write lost or index stuck");
    spi_wr_a: assert property ( // R15
        wr_evt && wr_req.idx != REG_DEV_ADDR
        |=> q.regs[$past(wr_req.idx)] == $past(wr_req.data))
        else $error("link write not stored");
    ro_addr_a: assert property ( // R18 R19
        q.regs[REG_DEV_ADDR][6:0] == REG_RESET[6:0]
        && rd_reg(q.regs, REG_DEV_ADDR, own_addr) == {q.regs[REG_DEV_ADDR][7],
        SLAVE_ADDR[6:1], q.a0_s})
        else $error("slave address bits became writable");
    irq_pin_a: assert property ( // R17
        core_data_ready |=> first_irq_or_data_ready_pin)
        else $error("data ready not shown on first interrupt pin");

    i2c_write_c: cover property (q.st == ST_WDATA_ACK ##1 q.st == ST_WDATA);
    i2c_burst_c: cover property (
        q.st == ST_MACK && q.mack ##1 q.st == ST_RDATA);
    spi_write_c: cover property (wr_evt);
    spi_read_c: cover property (
        rd_evt ##1 q.regs[REG_MODE_CTL][THREE_WIRE_POS]);

endmodule
`default_nettype wire

// [tb/dsras_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// host master: owns the shared clock, chip select and its own data drive
module dsras_host_model (
    output logic scl,
    output logic cs_n,
    output logic sda,
    input wire logic sda_in,
    input wire logic sdo
);
    localparam int Q = 80;
    // idle: clock high and still, two-wire selected, data left to pull-up
    initial
    begin
        scl = 1'b1;
        cs_n = 1'b1;
        sda = 1'b1;
    end
    // ----
    // two-wire bus, phases of 10 system clocks so sync stays comfortable
    // ----
    task automatic tw_bit(input logic b, output logic r);
        sda = b;
        #Q scl = 1'b1;
        #Q r = sda_in;
        #Q scl = 1'b0;
        #Q;
    endtask
    // serves as repeated start too, the clock being low by then
    task automatic tw_start();
        sda = 1'b1;
        #Q scl = 1'b1;
        #Q sda = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic tw_stop();
        sda = 1'b0;
        #Q scl = 1'b1;
        #Q sda = 1'b1;
        #Q;
    endtask
    task automatic tw_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            tw_bit(v[i], r);
        tw_bit(1'b1, r);
        ack = ~r;
    endtask
    // the last byte of a read is refused to end it
    task automatic tw_get(input logic more, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
            tw_bit(1'b1, v[i]);
        tw_bit(~more, r);
    endtask
    // ----
    // link frame: falling edge drives, rising edge samples
    // ----
    task automatic spi(input logic [23:0] tx, input int n, input logic w3,
        output logic [23:0] rx);
        rx = '0;
        cs_n = 1'b0;
        #Q;
        for (int i = n - 1; i >= 0; i--)
        begin
            scl = 1'b0;
            sda = tx[i];
            #Q scl = 1'b1;
            rx[i] = w3 ? sda_in : sdo;
            #Q;
        end
        cs_n = 1'b1;
        sda = 1'b1;
        #Q;
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dsras_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic a0 = 1'b1;
    logic [2:0] core = 3'h0;
    logic scl, cs_n, host_sda, sdio_o, sdio_oe, sdo_o, sdo_oe, pin1, pin2;
    wire logic sdio;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    // shared pin: device drive wins, else host or pull-up
    assign sdio = sdio_oe ? sdio_o : host_sda;
    always #4 clk_sys = ~clk_sys;
    dsras_top u_dut (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .serial_port_clock(scl),
        .cs_n(cs_n),
        .sdio_i(sdio),
        .sdio_o(sdio_o),
        .sdio_oe(sdio_oe),
        .sdo_o(sdo_o),
        .sdo_oe(sdo_oe),
        .slave_addr_bit0_pin(a0),
        .core_data_ready(core[2]),
        .core_irq1(core[1]),
        .core_irq2(core[0]),
        .first_irq_or_data_ready_pin(pin1),
        .second_irq_pin(pin2)
    );
    dsras_host_model u_host (
        .scl(scl),
        .cs_n(cs_n),
        .sda(host_sda),
        .sda_in(sdio),
        .sdo(sdo_oe ? sdo_o : ~sdo_o) // undriven pin reads inverted
    );
    // ----
    // checking and transfers
    // ----
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic tw_wr(input logic [7:0] idx, input logic [15:0] d);
        logic [3:0] k;
        u_host.tw_start();
        u_host.tw_byte({SLAVE_ADDR, 1'b0}, k[3]);
        u_host.tw_byte(idx, k[2]);
        u_host.tw_byte(d[15:8], k[1]);
        u_host.tw_byte(d[7:0], k[0]);
        u_host.tw_stop();
        check("write acks", 16'(k), 16'h000f);
    endtask
    task automatic tw_rd(input logic [7:0] idx, output logic [15:0] d);
        logic [2:0] k;
        u_host.tw_start();
        u_host.tw_byte({SLAVE_ADDR, 1'b0}, k[2]);
        u_host.tw_byte(idx, k[1]);
        u_host.tw_start();
        u_host.tw_byte({SLAVE_ADDR, 1'b1}, k[0]);
        u_host.tw_get(1'b1, d[15:8]);
        u_host.tw_get(1'b0, d[7:0]);
        u_host.tw_stop();
        check("read acks", 16'(k), 16'h0007);
    endtask
    task automatic tw_probe(input logic [7:0] a, output logic ack);
        u_host.tw_start();
        u_host.tw_byte(a, ack);
        u_host.tw_stop();
    endtask
    task automatic sp_wr(input logic [5:0] idx, input logic [15:0] d);
        logic [23:0] rx;
        u_host.spi({1'b1, idx, 1'b0, d}, 24, 1'b0, rx);
    endtask
    task automatic sp_rd(input logic [5:0] idx, input logic w3,
        output logic [15:0] d);
        logic [23:0] rx;
        u_host.spi({1'b0, idx, 1'b0, 16'hffff}, 24, w3, rx);
        d = rx[15:0];
        check("oe after frame", 16'({sdo_oe, sdio_oe}), 16'h0000);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_irq();
        logic [2:0] v;
        logic [1:0] e;
        for (int k = 0; k < 4; k++)
        begin
            v = 3'h4 >> k;
            e = {v[2] | v[1], v[0]};
            @(posedge clk_sys);
            #1 core = v;
            @(posedge clk_sys);
            #1 check("irq pins", 16'({pin1, pin2}), 16'(e));
        end
    endtask
    // index wraps from the top register to the bottom one
    task automatic t_tw();
        logic [15:0] d;
        tw_wr(8'h3f, 16'h5a3c);
        tw_rd(8'h3f, d);
        check("two-wire wrap read", d, 16'h5a3c);
        sp_rd(6'h00, 1'b0, d);
        check("link read after wrap", d, 16'h3c00);
    endtask
    task automatic t_refuse();
        logic [7:0] bad [5] = '{8'h00, 8'h01, 8'h08, 8'hf0, 8'h38};
        logic ack;
        foreach (bad[k])
        begin
            tw_probe(bad[k], ack);
            check("refused address", 16'(ack), 16'h0000);
        end
        @(posedge clk_sys);
        #1 a0 = 1'b0;
        tw_probe(8'h38, ack);
        check("strap low address", 16'(ack), 16'h0001);
        @(posedge clk_sys);
        #1 a0 = 1'b1;
    endtask
    task automatic t_spi();
        logic [15:0] d;
        sp_wr(6'h20, 16'h817e);
        sp_rd(6'h20, 1'b0, d);
        check("four-wire read", d, 16'h817e);
        sp_wr(REG_MODE_CTL, 16'h2000);
        sp_rd(6'h20, 1'b1, d);
        check("three-wire read", d, 16'h817e);
        sp_wr(REG_MODE_CTL, 16'h0000);
    endtask
    task automatic t_disable();
        logic [15:0] d;
        logic ack;
        for (int k = 0; k < 2; k++)
        begin
            sp_wr(REG_DEV_ADDR, k ? 16'h7f00 : 16'h8000);
            sp_rd(REG_DEV_ADDR, 1'b0, d);
            check("device address", d >> 8, 16'({k == 0, SLAVE_ADDR}));
            tw_probe({SLAVE_ADDR, 1'b0}, ack);
            check("two-wire enable", 16'(ack), 16'(k == 1));
        end
    endtask
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1 resetn = 1'b1;
        repeat (5) @(posedge clk_sys);
        check("pins after reset", 16'({pin1, pin2, sdio_oe}), 16'h0000);
        t_irq();
        t_tw();
        t_refuse();
        t_spi();
        t_disable();
        give_verdict();
    end
endmodule
`default_nettype wire
